// [logic/rti_pkg.sv]
// constants, register map and carrier types for the rtc counter block
// assumes a 32-bit axi4-lite master on the system clock
package rti_pkg;
   localparam int  RTI_AW           = 8;
   // printed offsets are not all word aligned: indices, byte addr = 4*index
   localparam logic [5:0] IDX_CTRL      = 6'h00;
   localparam logic [5:0] IDX_BUSY      = 6'h01;
   localparam logic [5:0] IDX_INT_EN    = 6'h02;
   localparam logic [5:0] IDX_FLAGS     = 6'h03;
   localparam logic [5:0] IDX_LATCH     = 6'h04;
   localparam logic [5:0] IDX_DEBUG     = 6'h05;
   localparam logic [5:0] IDX_DRIFT     = 6'h06;
   localparam logic [5:0] IDX_SOURCE    = 6'h07;
   localparam logic [5:0] IDX_COUNT_L   = 6'h08;
   localparam logic [5:0] IDX_COUNT_H   = 6'h09;
   localparam logic [5:0] IDX_LIMIT_L   = 6'h0a;
   localparam logic [5:0] IDX_LIMIT_H   = 6'h0b;
   localparam logic [5:0] IDX_MATCH_L   = 6'h0c;
   localparam logic [5:0] IDX_MATCH_H   = 6'h0d;
   localparam logic [5:0] IDX_PIT_CTRL  = 6'h10;
   localparam logic [5:0] IDX_PIT_EN    = 6'h12;
   localparam logic [5:0] IDX_PIT_FLAG  = 6'h13;
   localparam logic [5:0] IDX_IRQ_MASK  = 6'h14;
   localparam logic [5:0] IDX_IRQ_STAT  = 6'h16;
   localparam logic [15:0] LIMIT_RST    = 16'hffff;
   localparam logic [15:0] COUNT_RST    = 16'h0000;
   localparam logic [15:0] MATCH_RST    = 16'h0000;
   localparam logic [7:0]  BYTE_RST     = 8'h00;
   // field positions
   localparam int  BIT_WRAP         = 0;
   localparam int  BIT_MATCH        = 1;
   localparam int  BIT_PIT          = 2;
   localparam int  BIT_DRIFT_ON     = 2;
   localparam int  BIT_HALT_BYPASS  = 0;
   localparam int  BIT_SIGN         = 7;
   localparam int  BIT_PIT_ON       = 0;
   localparam int  BIT_BUSY_COUNT   = 1;
   localparam int  BIT_BUSY_LIMIT   = 2;
   localparam int  SYNC_CYCLES      = 2;
   localparam logic [19:0] PPM_SPAN = 20'd999999;
   localparam logic [3:0]  PIT_OFF  = 4'h0;
   localparam logic [3:0]  PIT_RSVD = 4'hf;
   localparam logic [1:0]  RESP_OK     = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      SRC_INTERNAL_FAST,
      SRC_INTERNAL_SLOW,
      SRC_CRYSTAL,
      SRC_PIN
   } rti_source_t;

   typedef struct packed {
      logic                 awvalid;
      logic [RTI_AW-1:0]    awaddr;
      logic                 wvalid;
      logic [31:0]          wdata;
      logic [3:0]           wstrb;
      logic                 bready;
      logic                 arvalid;
      logic [RTI_AW-1:0]    araddr;
      logic                 rready;
   } rti_axi_req_t;

   typedef struct packed {
      logic                 awready;
      logic                 wready;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 arready;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
   } rti_axi_rsp_t;

   typedef struct packed {
      logic internal_fast_source;
      logic internal_slow_source;
      logic crystal_source;
      logic pin_source;
   } rti_clk_in_t;
endpackage : rti_pkg

// [logic/rti_counter.sv]
// rtc tick counter with match, wrap, drift fix and interval timer
// assumes clock sources arrive as levels synchronous to aclk and are
// edge detected here; axi4-lite master on aclk
// Function
// - set match flag when count equals match value; write one clears
// - set wrap flag when count reaches limit and returns to zero
// - one shared byte latch gives atomic 16-bit register access
// - low byte at base offset, high byte at base plus one
// - with halt bypass zero, debug halt stops counter, drift and interval ticks; pending count and limit writes still land
// - sign zero slows prescaler, sign one speeds it up
// - seven-bit amount is clocks added or removed per million ticks
// - two-bit source pick selects one of four rtc clock sources
// - count write lands two rtc cycles later, busy flag meanwhile
// - limit write lands two rtc cycles later, busy flag meanwhile
// - interval code 0 off, 1..14 give 4..32768 cycles, 15 reserved
// - interval timer runs only while its on bit, bit 0 of the interval control byte, is one
// - interval flag set at each periodic tick; write one clears
// - drift fix applies only while drift fix on bit is one
// - match and wrap requests gated by enable bits 1 and 0
`timescale 1ns/1ns
module rti_counter
   import rti_pkg::*;
(
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire rti_pkg::rti_axi_req_t axi_req,
   output      rti_pkg::rti_axi_rsp_t axi_rsp,
   input  wire rti_pkg::rti_clk_in_t  clk_src,
   input  wire logic                 cpu_halted,
   output      logic                 irq
);
   import rti_pkg::*;

   // software registers
   logic [7:0]  ctrl_reg, int_en_reg, latch_reg, debug_reg, drift_reg;
   logic [7:0]  source_reg, pit_reg, pit_en_reg, irq_mask_reg;
   logic [15:0] match_reg, limit_reg, count_reg;
   logic [15:0] count_wr_reg, limit_wr_reg;
   logic [1:0]  flags_reg;
   logic        pit_flag_reg;
   logic [2:0]  irq_stat_reg;
   logic        irq_reg;
   logic [1:0]  count_busy_reg, limit_busy_reg;
   // rtc tick edge detect
   logic [1:0]  src_sync_reg;
   logic        src_prev_reg;
   logic [15:0] pit_cnt_reg;
   logic [19:0] ppm_cnt_reg;
   logic        pit_out_reg;
   // bus
   logic        aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
   logic [RTI_AW-1:0] awaddr_reg, araddr_reg;
   logic [31:0] wdata_reg, rdata_reg;
   logic [1:0]  bresp_reg, rresp_reg;

   // source selection and tick
   wire  rti_source_t src_sel = rti_source_t'(source_reg[1:0]);
   logic  src_level;
   always_comb begin
      case (src_sel)
         SRC_INTERNAL_FAST: src_level = clk_src.internal_fast_source;
         SRC_INTERNAL_SLOW: src_level = clk_src.internal_slow_source;
         SRC_CRYSTAL:       src_level = clk_src.crystal_source;
         default:           src_level = clk_src.pin_source;
      endcase
   end
   wire run_ok   = debug_reg[BIT_HALT_BYPASS] | ~cpu_halted;
   wire raw_tick = src_sync_reg[1] & ~src_prev_reg;
   wire tick     = raw_tick & run_ok;

   // drift fix: one extra or skipped tick per ppm window slot
   wire drift_on  = ctrl_reg[BIT_DRIFT_ON];
   wire ppm_wrap  = tick & (ppm_cnt_reg == PPM_SPAN);
   wire fix_slot  = drift_on & (drift_reg[6:0] != 7'h00) &
                    (ppm_cnt_reg < {13'h0, drift_reg[6:0]});
   // sign 0: swallow the tick (slower); sign 1: double step (faster)
   wire slow_skip = fix_slot & ~drift_reg[BIT_SIGN];
   wire fast_add  = fix_slot & drift_reg[BIT_SIGN];
   wire step      = tick & ~slow_skip;
   wire [15:0] step_by = fast_add ? 16'h0002 : 16'h0001;

   // counter with wrap and match
   wire        at_limit   = count_reg == limit_reg;
   wire        wrap_now   = step & at_limit;
   wire [16:0] count_sum  = {1'b0, count_reg} + {1'b0, step_by};
   wire [15:0] count_step = wrap_now ? 16'h0000 : count_sum[15:0];
   wire        count_land = count_busy_reg == 2'b01;
   wire        limit_land = limit_busy_reg == 2'b01;
   // a pending write lands on the rtc tick that ends its sync window
   wire [15:0] count_next = (count_land & raw_tick) ? count_wr_reg :
                            step ? count_step : count_reg;
   wire        match_now  = step & (count_step == match_reg);

   // interval timer
   wire [3:0]  pit_code = pit_reg[6:3];
   wire        pit_run  = pit_reg[BIT_PIT_ON] & (pit_code != PIT_OFF) &
                          (pit_code != PIT_RSVD);
   wire [15:0] pit_half = 16'h0001 << pit_code; // 2^code cycles, half of 2^(code+1)
   wire [15:0] pit_cnt_next = pit_run ? (tick ? pit_cnt_reg + 16'h0001 :
                                         pit_cnt_reg) : 16'h0000;
   wire        pit_out_next = pit_run & pit_cnt_next[pit_code];
   wire        pit_event = pit_out_next & ~pit_out_reg;

   // bus decode
   wire aw_ok = aw_hold_reg | axi_req.awvalid;
   wire w_ok  = w_hold_reg | axi_req.wvalid;
   wire [RTI_AW-1:0] wa = aw_hold_reg ? awaddr_reg : axi_req.awaddr;
   wire [31:0] wd = w_hold_reg ? wdata_reg : axi_req.wdata;
   wire do_wr = aw_ok & w_ok & ~bvalid_reg;
   wire wr_en = do_wr & (w_hold_reg | axi_req.wstrb[0]);
   wire [5:0] widx = wa[7:2];
   wire [7:0] wb   = wd[7:0];
   wire wr_mapped = (widx <= IDX_MATCH_H) | (widx == IDX_PIT_CTRL) |
                    (widx == IDX_PIT_EN) | (widx == IDX_PIT_FLAG) |
                    (widx == IDX_IRQ_MASK) | (widx == IDX_IRQ_STAT);
   wire w_ctrl  = wr_en & (widx == IDX_CTRL);
   wire w_inten = wr_en & (widx == IDX_INT_EN);
   wire w_flags = wr_en & (widx == IDX_FLAGS);
   wire w_latch = wr_en & (widx == IDX_LATCH);
   wire w_debug = wr_en & (widx == IDX_DEBUG);
   wire w_drift = wr_en & (widx == IDX_DRIFT);
   wire w_src   = wr_en & (widx == IDX_SOURCE);
   wire w_cnt_l = wr_en & (widx == IDX_COUNT_L);
   wire w_cnt_h = wr_en & (widx == IDX_COUNT_H);
   wire w_lim_l = wr_en & (widx == IDX_LIMIT_L);
   wire w_lim_h = wr_en & (widx == IDX_LIMIT_H);
   wire w_mat_l = wr_en & (widx == IDX_MATCH_L);
   wire w_mat_h = wr_en & (widx == IDX_MATCH_H);
   wire w_pit   = wr_en & (widx == IDX_PIT_CTRL);
   wire w_interval_timer_on = wr_en & (widx == IDX_PIT_EN);
   wire w_pitf  = wr_en & (widx == IDX_PIT_FLAG);
   wire w_mask  = wr_en & (widx == IDX_IRQ_MASK);
   wire w_stat  = wr_en & (widx == IDX_IRQ_STAT);
   // high-byte writes commit latch (low) plus new high byte at once
   wire [15:0] wr16 = {wb, latch_reg};

   // read decode; reading a low byte parks the high byte in the latch
   wire do_rd = axi_req.arvalid & ~rvalid_reg;
   wire [5:0] ridx = axi_req.araddr[7:2];
   wire [7:0] busy_byte = {5'h0, |limit_busy_reg, |count_busy_reg, 1'b0};
   logic [7:0] rbyte;
   logic       rmapped;
   always_comb begin
      rmapped = 1'b1;
      if (ridx == IDX_CTRL) rbyte = ctrl_reg;
      else if (ridx == IDX_BUSY) rbyte = busy_byte;
      else if (ridx == IDX_INT_EN) rbyte = int_en_reg;
      else if (ridx == IDX_FLAGS) rbyte = {6'h0, flags_reg};
      else if (ridx == IDX_LATCH) rbyte = latch_reg;
      else if (ridx == IDX_DEBUG) rbyte = debug_reg;
      else if (ridx == IDX_DRIFT) rbyte = drift_reg;
      else if (ridx == IDX_SOURCE) rbyte = source_reg;
      else if (ridx == IDX_COUNT_L) rbyte = count_reg[7:0];
      else if (ridx == IDX_COUNT_H) rbyte = latch_reg;
      else if (ridx == IDX_LIMIT_L) rbyte = limit_reg[7:0];
      else if (ridx == IDX_LIMIT_H) rbyte = latch_reg;
      else if (ridx == IDX_MATCH_L) rbyte = match_reg[7:0];
      else if (ridx == IDX_MATCH_H) rbyte = latch_reg;
      else if (ridx == IDX_PIT_CTRL) rbyte = pit_reg;
      else if (ridx == IDX_PIT_EN) rbyte = pit_en_reg;
      else if (ridx == IDX_PIT_FLAG) rbyte = {7'h0, pit_flag_reg};
      else if (ridx == IDX_IRQ_MASK) rbyte = irq_mask_reg;
      else if (ridx == IDX_IRQ_STAT) rbyte = {5'h0, irq_stat_reg};
      else begin
         rbyte   = 8'h00;
         rmapped = 1'b0;
      end
   end
   wire r_lo_cnt = do_rd & (ridx == IDX_COUNT_L);
   wire r_lo_lim = do_rd & (ridx == IDX_LIMIT_L);
   wire r_lo_mat = do_rd & (ridx == IDX_MATCH_L);
   wire [7:0] latch_next =
      r_lo_cnt ? count_reg[15:8] : r_lo_lim ? limit_reg[15:8] :
      r_lo_mat ? match_reg[15:8] : (w_latch | w_cnt_l | w_lim_l |
      w_mat_l) ? wb : latch_reg;

   // events: set wins over write-one clear
   wire [1:0] ev_rtc = {match_now, wrap_now};
   wire [1:0] flags_next = ev_rtc | (flags_reg &
                           ~(w_flags ? wb[1:0] : 2'b00));
   wire pit_flag_next = pit_event |
                        (pit_flag_reg & ~(w_pitf & wb[0]));
   wire [2:0] ev_all = {pit_event, match_now, wrap_now};
   wire [2:0] stat_next = ev_all | (irq_stat_reg &
                          ~(w_stat ? wb[2:0] : 3'h0));
   wire [2:0] req_lvl = {pit_flag_reg & pit_en_reg[0],
                         flags_reg[BIT_MATCH] & int_en_reg[BIT_MATCH],
                         flags_reg[BIT_WRAP] & int_en_reg[BIT_WRAP]};
   wire irq_next = |(req_lvl | (irq_stat_reg & irq_mask_reg[2:0]));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= BYTE_RST; int_en_reg <= BYTE_RST;
         latch_reg <= BYTE_RST; debug_reg <= BYTE_RST;
         drift_reg <= BYTE_RST; source_reg <= BYTE_RST;
         pit_reg <= BYTE_RST; pit_en_reg <= BYTE_RST;
         irq_mask_reg <= BYTE_RST;
         match_reg <= MATCH_RST; limit_reg <= LIMIT_RST;
         count_reg <= COUNT_RST; count_wr_reg <= COUNT_RST;
         limit_wr_reg <= LIMIT_RST;
         flags_reg <= 2'b00; pit_flag_reg <= 1'b0;
         irq_stat_reg <= 3'h0; irq_reg <= 1'b0;
         count_busy_reg <= 2'b00; limit_busy_reg <= 2'b00;
         src_sync_reg <= 2'b00; src_prev_reg <= 1'b0;
         pit_cnt_reg <= 16'h0000; ppm_cnt_reg <= 20'h00000;
         pit_out_reg <= 1'b0;
      end else begin
         src_sync_reg <= {src_sync_reg[0], src_level};
         src_prev_reg <= src_sync_reg[1];
         ppm_cnt_reg  <= ppm_wrap ? 20'h00000 :
                         tick ? ppm_cnt_reg + 20'h00001 : ppm_cnt_reg;
         if (w_ctrl) ctrl_reg <= wb;
         if (w_inten) int_en_reg <= {6'h0, wb[1:0]};
         if (w_debug) debug_reg <= {7'h0, wb[0]};
         if (w_drift) drift_reg <= wb;
         if (w_src) source_reg <= {6'h0, wb[1:0]};
         if (w_pit) pit_reg <= {1'b0, wb[6:3], 2'b00, wb[0]};
         if (w_interval_timer_on) pit_en_reg <= {7'h0, wb[0]};
         if (w_mask) irq_mask_reg <= {5'h0, wb[2:0]};
         if (w_mat_h) match_reg <= wr16;
         latch_reg <= latch_next;
         // two rtc ticks of synchronisation before a write lands
         if (w_cnt_h && count_busy_reg == 2'b00) begin
            count_wr_reg   <= wr16;
            count_busy_reg <= 2'(SYNC_CYCLES);
         end else if (raw_tick && count_busy_reg != 2'b00)
            count_busy_reg <= count_busy_reg - 2'b01;
         if (w_lim_h && limit_busy_reg == 2'b00) begin
            limit_wr_reg   <= wr16;
            limit_busy_reg <= 2'(SYNC_CYCLES);
         end else if (raw_tick && limit_busy_reg != 2'b00)
            limit_busy_reg <= limit_busy_reg - 2'b01;
         count_reg <= count_next;
         if (limit_land && raw_tick) limit_reg <= limit_wr_reg;
         pit_cnt_reg  <= pit_cnt_next;
         pit_out_reg  <= pit_out_next;
         flags_reg    <= flags_next;
         pit_flag_reg <= pit_flag_next;
         irq_stat_reg <= stat_next;
         irq_reg      <= irq_next;
      end
   end

   // axi4-lite slave: single outstanding write and read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0; w_hold_reg <= 1'b0;
         awaddr_reg <= '0; wdata_reg <= 32'h0;
         bvalid_reg <= 1'b0; bresp_reg <= RESP_OK;
         rvalid_reg <= 1'b0; rdata_reg <= 32'h0; rresp_reg <= RESP_OK;
      end else begin
         if (do_wr) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_mapped ? RESP_OK : RESP_SLVERR;
         end else begin
            if (axi_req.awvalid && !aw_hold_reg && !bvalid_reg) begin
               aw_hold_reg <= 1'b1;
               awaddr_reg  <= axi_req.awaddr;
            end
            if (axi_req.wvalid && !w_hold_reg && !bvalid_reg) begin
               w_hold_reg <= axi_req.wstrb[0];
               wdata_reg  <= axi_req.wdata;
            end
            if (bvalid_reg && axi_req.bready) bvalid_reg <= 1'b0;
         end
         if (do_rd) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {24'h0, rbyte};
            rresp_reg  <= rmapped ? RESP_OK : RESP_SLVERR;
         end else if (rvalid_reg && axi_req.rready)
            rvalid_reg <= 1'b0;
      end
   end

   assign axi_rsp.awready = ~aw_hold_reg & ~bvalid_reg;
   assign axi_rsp.wready  = ~w_hold_reg & ~bvalid_reg;
   assign axi_rsp.bvalid  = bvalid_reg;
   assign axi_rsp.bresp   = bresp_reg;
   assign axi_rsp.arready = ~rvalid_reg;
   assign axi_rsp.rvalid  = rvalid_reg;
   assign axi_rsp.rdata   = rdata_reg;
   assign axi_rsp.rresp   = rresp_reg;
   assign irq             = irq_reg;
endmodule : rti_counter

// [tb/rti_counter_chk.sv]
// port checker for the rtc counter block
// assumes it is bound to rti_counter and sees only its ports
`timescale 1ns/1ns
module rti_counter_chk
   import rti_pkg::*;
(
   input wire logic                  aclk,
   input wire logic                  aresetn,
   input wire rti_pkg::rti_axi_req_t axi_req,
   input wire rti_pkg::rti_axi_rsp_t axi_rsp,
   input wire rti_pkg::rti_clk_in_t  clk_src,
   input wire logic                  cpu_halted,
   input wire logic                  irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire wr_take = axi_req.awvalid && axi_rsp.awready
                  && axi_req.wvalid && axi_rsp.wready;
   wire rd_take = axi_req.arvalid && axi_rsp.arready;
   wire bad_wr  = wr_take && axi_req.awaddr == 8'h38;
   wire bad_rd  = rd_take && axi_req.araddr == 8'h38;

   a_wr_answer: assert property (wr_take |=> axi_rsp.bvalid)
      else $error("write not answered in one cycle");
   a_rd_answer: assert property (rd_take |=> axi_rsp.rvalid)
      else $error("read not answered in one cycle");
   a_b_done: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
      else $error("write response not released");
   a_r_done: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
      else $error("read response not released");
   a_ar_refused: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
      else $error("read taken while answer pending");
   a_aw_refused: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
      else $error("write taken while answer pending");
   a_bad_wr: assert property (bad_wr |=> axi_rsp.bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   a_bad_rd: assert property (bad_rd |=> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0)
      else $error("unmapped read not refused");
   a_irq_reset: assert property ($rose(aresetn) |-> !irq)
      else $error("irq high out of reset");

   c_write: cover property (wr_take);
   c_read:  cover property (rd_take);
   c_irq:   cover property ($rose(irq));
endmodule : rti_counter_chk

bind rti_counter rti_counter_chk u_chk (.aclk(aclk), .aresetn(aresetn),
   .axi_req(axi_req), .axi_rsp(axi_rsp), .clk_src(clk_src),
   .cpu_halted(cpu_halted), .irq(irq));

// [tb/rti_counter_bench.sv]
// self-checking bench for the rtc counter block
// assumes byte address = 4*index and slow sources far below aclk/4
`timescale 1ns/1ns
module rti_counter_bench;
   import rti_pkg::*;
   logic         aclk, aresetn, cpu_halted;
   logic         irq;
   logic [3:0]   src_v;
   rti_axi_req_t req;
   rti_axi_rsp_t rsp;
   int           n_fail, num_checks;
   logic [7:0]   q;
   logic [1:0]   r;

   rti_counter u_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
      .axi_rsp(rsp), .clk_src(rti_clk_in_t'(src_v)),
      .cpu_halted(cpu_halted), .irq(irq));

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic acc(bit w, logic [5:0] i, logic [7:0] d);
      int t;
      @(posedge aclk);
      req.awaddr  <= {i, 2'b00};
      req.araddr  <= {i, 2'b00};
      req.wdata   <= {24'h0, d};
      req.awvalid <= w;
      req.wvalid  <= w;
      req.bready  <= w;
      req.arvalid <= !w;
      req.rready  <= !w;
      for (t = 0; t < 40; t++) begin
         @(posedge aclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.arready) req.arvalid <= 1'b0;
         if (w ? rsp.bvalid : rsp.rvalid) break;
      end
      if (t == 40) n_fail++;
      q = rsp.rdata[7:0];
      r = w ? rsp.bresp : rsp.rresp;
      req.bready <= 1'b0;
      req.rready <= 1'b0;
   endtask : acc

   task automatic wr(logic [5:0] i, logic [7:0] d);
      acc(1'b1, i, d);
   endtask : wr

   task automatic rd(logic [5:0] i, logic [7:0] e, string nm);
      acc(1'b0, i, 8'h00);
      check(nm, q, e);
   endtask : rd

   // one slow-clock period per tick on source k
   task automatic tick(int k, int n);
      repeat (n) begin
         src_v[3-k] <= 1'b1;
         repeat (4) @(posedge aclk);
         src_v[3-k] <= 1'b0;
         repeat (6) @(posedge aclk);
      end
   endtask : tick

   task automatic t_reset();
      logic [5:0] ri[11] = '{IDX_LATCH, IDX_DEBUG, IDX_DRIFT, IDX_SOURCE,
         IDX_COUNT_L, IDX_COUNT_H, IDX_LIMIT_L, IDX_LIMIT_H, IDX_MATCH_L,
         IDX_MATCH_H, IDX_PIT_CTRL};
      logic [7:0] re[11] = '{BYTE_RST, 8'h00, 8'h00, 8'h00, COUNT_RST[7:0],
         COUNT_RST[15:8], LIMIT_RST[7:0], LIMIT_RST[15:8], MATCH_RST[7:0],
         MATCH_RST[15:8], 8'h00};
      for (int j = 0; j < 11; j++) rd(ri[j], re[j], "reset value");
      check("irq", {7'h0, irq}, 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_latch();
      wr(IDX_LATCH, 8'h5a);
      rd(IDX_LATCH, 8'h5a, "byte latch");
      wr(IDX_MATCH_L, 8'h34);
      rd(IDX_LATCH, 8'h34, "latch low");
      wr(IDX_MATCH_H, 8'h12);
      rd(IDX_MATCH_L, 8'h34, "match low");
      rd(IDX_LATCH, 8'h12, "parked high");
      rd(IDX_MATCH_H, 8'h12, "match high");
      $display("test latch done");
   endtask : t_latch

   task automatic t_flags();
      wr(IDX_MATCH_L, 8'h03);
      wr(IDX_MATCH_H, 8'h00);
      wr(IDX_INT_EN, 8'h03);
      wr(IDX_COUNT_L, 8'h02);
      wr(IDX_COUNT_H, 8'h00);
      wr(IDX_LIMIT_L, 8'h03);
      wr(IDX_LIMIT_H, 8'h00);
      rd(IDX_BUSY, 8'h06, "sync busy");
      tick(0, 2);
      rd(IDX_BUSY, 8'h00, "sync idle");
      wr(IDX_FLAGS, 8'h03);
      rd(IDX_COUNT_L, 8'h02, "landed count");
      tick(0, 1);
      rd(IDX_FLAGS, 8'h02, "match flag");
      check("irq", {7'h0, irq}, 8'h01);
      tick(0, 1);
      rd(IDX_FLAGS, 8'h03, "wrap flag");
      rd(IDX_COUNT_L, 8'h00, "wrapped count");
      wr(IDX_FLAGS, 8'h02);
      rd(IDX_FLAGS, 8'h01, "match cleared");
      wr(IDX_INT_EN, 8'h02);
      repeat (3) @(posedge aclk);
      check("irq", {7'h0, irq}, 8'h00);
      wr(IDX_FLAGS, 8'h01);
      rd(IDX_FLAGS, 8'h00, "wrap cleared");
      $display("test flags done");
   endtask : t_flags

   task automatic t_halt();
      cpu_halted <= 1'b1;
      tick(0, 3);
      rd(IDX_COUNT_L, 8'h00, "halted count");
      wr(IDX_DEBUG, 8'h01);
      tick(0, 3);
      rd(IDX_COUNT_L, 8'h03, "bypass count");
      cpu_halted <= 1'b0;
      wr(IDX_DEBUG, 8'h00);
      $display("test halt done");
   endtask : t_halt

   task automatic t_source();
      logic [7:0] c;
      c = 8'h03;
      for (int s = 0; s < 4; s++) begin
         wr(IDX_SOURCE, 8'(s));
         rd(IDX_SOURCE, 8'(s), "source");
         tick((s + 1) % 4, 1);
         rd(IDX_COUNT_L, c, "unselected");
         tick(s, 1);
         c = (c + 8'h01) & 8'h03;
         rd(IDX_COUNT_L, c, "selected");
      end
      wr(IDX_SOURCE, 8'h00);
      $display("test source done");
   endtask : t_source

   task automatic t_pit();
      wr(IDX_INT_EN, 8'h00);
      wr(IDX_PIT_EN, 8'h01);
      wr(IDX_PIT_CTRL, 8'h08);
      tick(0, 8);
      rd(IDX_PIT_FLAG, 8'h00, "timer off");
      wr(IDX_PIT_CTRL, 8'h09);
      tick(0, 8);
      rd(IDX_PIT_FLAG, 8'h01, "interval flag");
      check("irq", {7'h0, irq}, 8'h01);
      wr(IDX_PIT_CTRL, 8'h01);
      wr(IDX_PIT_FLAG, 8'h01);
      rd(IDX_PIT_FLAG, 8'h00, "flag cleared");
      tick(0, 8);
      rd(IDX_PIT_FLAG, 8'h00, "code off");
      wr(IDX_PIT_CTRL, 8'h79);
      tick(0, 8);
      rd(IDX_PIT_FLAG, 8'h00, "code reserved");
      check("irq", {7'h0, irq}, 8'h00);
      $display("test pit done");
   endtask : t_pit

   task automatic t_misc();
      wr(IDX_DRIFT, 8'h85);
      rd(IDX_DRIFT, 8'h85, "drift");
      wr(IDX_CTRL, 8'h04);
      rd(IDX_CTRL, 8'h04, "drift fix on");
      // still early in the ppm window: every tick falls in a fix slot
      wr(IDX_DRIFT, 8'h7f);
      tick(0, 2);
      rd(IDX_COUNT_L, 8'h03, "slowed count");
      wr(IDX_DRIFT, 8'hff);
      tick(0, 2);
      rd(IDX_COUNT_L, 8'h02, "faster count");
      wr(IDX_CTRL, 8'h00);
      tick(0, 1);
      rd(IDX_COUNT_L, 8'h03, "fix off count");
      acc(1'b0, 6'h0e, 8'h00);
      check("bad read", {r, q[5:0]}, {RESP_SLVERR, 6'h00});
      wr(6'h0e, 8'h11);
      check("bad write", {6'h0, r}, {6'h0, RESP_SLVERR});
      $display("test misc done");
   endtask : t_misc

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize

   initial begin
      repeat (30000) @(posedge aclk);
      n_fail++;
      summarize();
   end

   initial begin
      aresetn = 1'b0;
      cpu_halted = 1'b0;
      src_v = 4'h0;
      req = '0;
      req.wstrb = 4'hf;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_latch();
      t_flags();
      t_halt();
      t_source();
      t_pit();
      t_misc();
      summarize();
   end
endmodule : rti_counter_bench
